// ### common/frame_buffer_map.vh
// Register offsets, field positions, reset values and timing for the frame buffer block.
// Assumes a 10 MHz core clock; host access is a byte-wise serial link, mode 0.
`ifndef FRAME_BUFFER_MAP_VH
`define FRAME_BUFFER_MAP_VH

// Register offsets
`define REG_TX_POWER_CONFIG 6'h05
`define REG_SIGNAL_STRENGTH 6'h06
`define REG_ENERGY_DETECT 6'h07

// Field positions and reset values
`define AUTO_CRC_BIT 7
`define TX_POWER_CONFIG_RESET 8'h00
`define LEVEL_RESET 8'h00

// Serial command byte layout
`define CMD_REG_BIT 7
`define CMD_WRITE_BIT 6
`define CMD_FRAME_BIT 5

// Buffer geometry and value limits
`define BUF_DEPTH 128
`define ED_MAX 8'h54
`define RSSI_MAX 5'h1C
`define ED_SYMBOLS 4'h8

// Timing, in microseconds, and the clock rate in MHz
`define CLK_MHZ 10
`define OVERWRITE_DELAY_US 32
`define ED_VALID_US 140
`define RSSI_REFRESH_US 2
`define SYMBOL_US 16

`endif

// ### hdl/frame_buffer.v
// Dual-ported 128-byte frame store with energy-detect and signal-strength levels.
// Assumes engine signals share clk_i; serial host pins are asynchronous and synchronised here.
`timescale 1ns/1ps
`include "frame_buffer_map.vh"

module frame_buffer (
	input wire clk_i,
	input wire rst_n_i,
	input wire spi_sclk_i,
	input wire spi_sel_n_i,
	input wire spi_mosi_i,
	output reg spi_miso_o,
	output wire spi_miso_oe_o,
	input wire rx_state_i,
	input wire auto_retry_tx_state_i,
	input wire sleep_i,
	input wire power_on_i,
	input wire frame_start_i,
	input wire rx_byte_valid_i,
	input wire [7:0] rx_byte_i,
	input wire frame_end_i,
	input wire [7:0] link_quality_i,
	input wire [4:0] rssi_raw_i,
	input wire tx_start_i,
	input wire tx_byte_req_i,
	output reg [7:0] tx_byte_o,
	output reg buffer_access_conflict_irq_o
);

	// Cycle counts worked out at full width, then cut to their counters
	localparam integer OVW_CYC_W = `OVERWRITE_DELAY_US * `CLK_MHZ;
	localparam integer ED_CYC_W = `ED_VALID_US * `CLK_MHZ;
	localparam integer RSSI_CYC_W = `RSSI_REFRESH_US * `CLK_MHZ;
	localparam integer SYM_CYC_W = `SYMBOL_US * `CLK_MHZ;
	localparam [8:0] OVW_CYC = OVW_CYC_W[8:0];
	localparam [10:0] ED_CYC = ED_CYC_W[10:0];
	localparam [4:0] RSSI_CYC = RSSI_CYC_W[4:0];
	localparam [7:0] SYM_CYC = SYM_CYC_W[7:0];
	localparam [1:0] PH_CMD = 2'b00;
	localparam [1:0] PH_ADDR = 2'b01;
	localparam [1:0] PH_DATA = 2'b10;

	// One step of the reflected ITU checksum, one byte, low bit first
	function [15:0] crc_byte;
		input [15:0] crc;
		input [7:0] data;
		integer i;
		reg [15:0] c;
		begin
			c = crc;
			for (i = 0; i < 8; i = i + 1) begin
				if (c[0] ^ data[i])
					c = (c >> 1) ^ 16'h8408;
				else
					c = c >> 1;
			end
			crc_byte = c;
		end
	endfunction

	reg [7:0] mem [0:`BUF_DEPTH-1];
	wire powered = ~sleep_i & ~power_on_i;

	// ----------------------------------------------------------------
	// Serial pin synchronisers and edge detection
	// ----------------------------------------------------------------
	reg [1:0] sclk_q, sel_q, mosi_q;
	reg sclk_prev_q;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_q <= 2'b00;
			sel_q <= 2'b11;
			mosi_q <= 2'b00;
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_q <= {sclk_q[0], spi_sclk_i};
			sel_q <= {sel_q[0], spi_sel_n_i};
			mosi_q <= {mosi_q[0], spi_mosi_i};
			sclk_prev_q <= sclk_q[1];
		end
	end
	wire selected = ~sel_q[1];
	wire sclk_rise = selected & sclk_q[1] & ~sclk_prev_q;
	wire sclk_fall = selected & ~sclk_q[1] & sclk_prev_q;
	assign spi_miso_oe_o = selected;

	// ----------------------------------------------------------------
	// Serial byte engine and command decode
	// ----------------------------------------------------------------
	reg [2:0] bit_q;
	reg [7:0] in_q, out_q, cmd_q, cfg_q;
	reg [1:0] phase_q;
	reg [6:0] hptr_q;
	reg host_buf_q, host_wr_pend_q, ed_trig_q;
	reg [7:0] host_wr_data_q;
	reg [6:0] host_wr_addr_q;
	wire [7:0] rx_in = {in_q[6:0], mosi_q[1]};
	wire byte_done = sclk_rise & (bit_q == 3'h7);
	wire cmd_reg = rx_in[`CMD_REG_BIT];
	wire cmd_wr = rx_in[`CMD_WRITE_BIT];
	reg [7:0] ed_q, rssi_q;
	reg rx_owns_q;

	// Host view of one buffer byte, gated off while unpowered
	function [7:0] buf_read;
		input [6:0] idx;
		input frame_mode;
		begin
			if (!powered)
				buf_read = 8'h00;
			else if (idx == 7'h00 && frame_mode)
				buf_read = {1'b0, mem[0][6:0]};
			else if (idx == 7'h00)
				buf_read = 8'h00;
			else
				buf_read = mem[idx];
		end
	endfunction

	// Register read decode
	function [7:0] reg_read;
		input [5:0] addr;
		begin
			case (addr)
				`REG_TX_POWER_CONFIG: reg_read = cfg_q;
				`REG_SIGNAL_STRENGTH: reg_read = rssi_q;
				`REG_ENERGY_DETECT: reg_read = rx_state_i ? ed_q : 8'h00;
				default: reg_read = 8'h00;
			endcase
		end
	endfunction

	// Byte assembly, phase sequencing and response loading
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_q <= 3'h0;
			in_q <= 8'h00;
			out_q <= 8'h00;
			spi_miso_o <= 1'b0;
			cmd_q <= 8'h00;
			cfg_q <= `TX_POWER_CONFIG_RESET;
			phase_q <= PH_CMD;
			hptr_q <= 7'h00;
			host_buf_q <= 1'b0;
			host_wr_pend_q <= 1'b0;
			host_wr_data_q <= 8'h00;
			host_wr_addr_q <= 7'h00;
			ed_trig_q <= 1'b0;
		end else begin
			host_wr_pend_q <= 1'b0;
			ed_trig_q <= 1'b0;
			if (!selected) begin
				bit_q <= 3'h0;
				phase_q <= PH_CMD;
				host_buf_q <= 1'b0;
				out_q <= 8'h00;
				spi_miso_o <= 1'b0;
			end else begin
				if (sclk_fall) begin
					spi_miso_o <= out_q[7];
					out_q <= {out_q[6:0], 1'b0};
				end
				if (sclk_rise) begin
					bit_q <= bit_q + 3'h1;
					in_q <= rx_in;
				end
				if (byte_done) begin
					case (phase_q)
						PH_CMD: begin
							cmd_q <= rx_in;
							hptr_q <= 7'h00;
							if (cmd_reg) begin
								phase_q <= PH_DATA;
								out_q <= cmd_wr ? 8'h00 : reg_read(rx_in[5:0]);
							end else if (rx_in[`CMD_FRAME_BIT]) begin
								phase_q <= PH_DATA;
								host_buf_q <= 1'b1;
								out_q <= cmd_wr ? 8'h00 : buf_read(7'h00, 1'b1);
								hptr_q <= cmd_wr ? 7'h00 : 7'h01;
							end else begin
								phase_q <= PH_ADDR;
								out_q <= 8'h00;
							end
						end
						PH_ADDR: begin
							phase_q <= PH_DATA;
							host_buf_q <= 1'b1;
							out_q <= cmd_q[`CMD_WRITE_BIT] ? 8'h00 : buf_read(rx_in[6:0], 1'b0);
							hptr_q <= cmd_q[`CMD_WRITE_BIT] ? rx_in[6:0] : rx_in[6:0] + 7'h01;
						end
						PH_DATA: begin
							if (cmd_q[`CMD_REG_BIT]) begin
								if (cmd_q[`CMD_WRITE_BIT]) begin
									if (cmd_q[5:0] == `REG_TX_POWER_CONFIG)
										cfg_q <= rx_in;
									if (cmd_q[5:0] == `REG_ENERGY_DETECT)
										ed_trig_q <= 1'b1;
								end
								out_q <= 8'h00;
							end else if (cmd_q[`CMD_WRITE_BIT]) begin
								host_wr_pend_q <= powered;
								host_wr_data_q <= rx_in;
								host_wr_addr_q <= hptr_q;
								hptr_q <= hptr_q + 7'h01;
								out_q <= 8'h00;
							end else begin
								out_q <= buf_read(hptr_q, 1'b0);
								hptr_q <= hptr_q + 7'h01;
							end
						end
						default: phase_q <= PH_CMD;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive overwrite timing and engine write port
	// ----------------------------------------------------------------
	reg [8:0] ovw_cnt_q;
	reg ovw_wait_q;
	reg [6:0] rptr_q;
	wire store_rx = rx_state_i & ~auto_retry_tx_state_i & powered;
	wire ovw_start = ovw_wait_q & (ovw_cnt_q == OVW_CYC - 9'h001);
	wire rx_wr = rx_owns_q & rx_byte_valid_i & store_rx;
	wire lqi_wr = rx_owns_q & frame_end_i & store_rx;

	// Delay from frame start to buffer takeover
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovw_wait_q <= 1'b0;
			ovw_cnt_q <= 9'h000;
			rx_owns_q <= 1'b0;
			rptr_q <= 7'h00;
		end else begin
			if (frame_start_i & store_rx) begin
				ovw_wait_q <= 1'b1;
				ovw_cnt_q <= 9'h000;
			end else if (ovw_start) begin
				ovw_wait_q <= 1'b0;
			end else if (ovw_wait_q) begin
				ovw_cnt_q <= ovw_cnt_q + 9'h001;
			end
			if (ovw_start) begin
				rx_owns_q <= 1'b1;
				rptr_q <= 7'h00;
			end else if (lqi_wr | ~store_rx) begin
				rx_owns_q <= 1'b0;
			end else if (rx_wr) begin
				rptr_q <= rptr_q + 7'h01;
			end
		end
	end

	// Single write port: engine data wins over host data
	always @(posedge clk_i) begin
		if (rx_wr)
			mem[rptr_q] <= (rptr_q == 7'h00) ? {1'b0, rx_byte_i[6:0]} : rx_byte_i;
		else if (lqi_wr)
			mem[rptr_q] <= link_quality_i;
		else if (host_wr_pend_q)
			mem[host_wr_addr_q] <= host_wr_data_q;
	end

	// ----------------------------------------------------------------
	// Transmit read port with checksum substitution
	// ----------------------------------------------------------------
	reg [6:0] tptr_q;
	reg [15:0] crc_q;
	reg tx_busy_q;
	wire [6:0] tx_len = mem[0][6:0];
	wire auto_crc = cfg_q[`AUTO_CRC_BIT] & (tx_len >= 7'h03);
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tptr_q <= 7'h00;
			crc_q <= 16'h0000;
			tx_byte_o <= 8'h00;
			tx_busy_q <= 1'b0;
		end else if (tx_start_i) begin
			tptr_q <= 7'h00;
			crc_q <= 16'h0000;
			tx_busy_q <= 1'b1;
		end else if (tx_byte_req_i) begin
			tptr_q <= tptr_q + 7'h01;
			if (tptr_q == tx_len)
				tx_busy_q <= 1'b0;
			if (auto_crc && tptr_q == tx_len - 7'h01) begin
				tx_byte_o <= crc_q[7:0];
			end else if (auto_crc && tptr_q == tx_len) begin
				tx_byte_o <= crc_q[15:8];
			end else begin
				tx_byte_o <= mem[tptr_q];
				if (tptr_q != 7'h00)
					crc_q <= crc_byte(crc_q, mem[tptr_q]);
			end
		end
	end

	// ----------------------------------------------------------------
	// Conflict event
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			buffer_access_conflict_irq_o <= 1'b0;
		else
			buffer_access_conflict_irq_o <= (host_buf_q & ovw_start)
				| (host_wr_pend_q & (rx_wr | lqi_wr | tx_busy_q));
	end

	// ----------------------------------------------------------------
	// Signal strength and energy detection
	// ----------------------------------------------------------------
	reg [4:0] rssi_cnt_q;
	reg [10:0] ed_cnt_q;
	reg [7:0] sym_cnt_q;
	reg [3:0] ed_n_q;
	reg [7:0] ed_sum_q;
	reg ed_run_q;
	wire [4:0] rssi_clamped = (rssi_raw_i > `RSSI_MAX) ? `RSSI_MAX : rssi_raw_i;
	wire [9:0] ed_scaled = {2'b00, ed_sum_q} * 10'h003;
	wire [7:0] ed_avg = {1'b0, ed_scaled[9:3]};
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rssi_q <= `LEVEL_RESET;
			rssi_cnt_q <= 5'h00;
			ed_q <= `LEVEL_RESET;
			ed_cnt_q <= 11'h000;
			sym_cnt_q <= 8'h00;
			ed_n_q <= 4'h0;
			ed_sum_q <= 8'h00;
			ed_run_q <= 1'b0;
		end else begin
			// Periodic strength refresh while receiving
			if (!rx_state_i) begin
				rssi_q <= 8'h00;
				rssi_cnt_q <= 5'h00;
			end else if (rssi_cnt_q == RSSI_CYC - 5'h01) begin
				rssi_q <= {3'b000, rssi_clamped};
				rssi_cnt_q <= 5'h00;
			end else begin
				rssi_cnt_q <= rssi_cnt_q + 5'h01;
			end
			// Eight-symbol average, started by delimiter or host write
			if (!rx_state_i) begin
				ed_q <= 8'h00;
				ed_run_q <= 1'b0;
			end else if (frame_start_i | ed_trig_q) begin
				ed_q <= 8'h00;
				ed_run_q <= 1'b1;
				ed_cnt_q <= 11'h000;
				sym_cnt_q <= 8'h00;
				ed_n_q <= 4'h0;
				ed_sum_q <= 8'h00;
			end else if (ed_run_q) begin
				ed_cnt_q <= ed_cnt_q + 11'h001;
				if (sym_cnt_q == SYM_CYC - 8'h01) begin
					sym_cnt_q <= 8'h00;
					if (ed_n_q != `ED_SYMBOLS) begin
						ed_sum_q <= ed_sum_q + {3'b000, rssi_clamped};
						ed_n_q <= ed_n_q + 4'h1;
					end
				end else begin
					sym_cnt_q <= sym_cnt_q + 8'h01;
				end
				if (ed_cnt_q == ED_CYC - 11'h001) begin
					ed_run_q <= 1'b0;
					ed_q <= (ed_avg > `ED_MAX) ? `ED_MAX : ed_avg;
				end
			end
		end
	end

endmodule // frame_buffer

// ### verif/frame_buffer_monitor.sv
// Port-level assertions for the frame buffer.
// Assumes a bind onto frame_buffer; one clock domain.
`timescale 1ns/1ps
module frame_buffer_monitor (
	input wire clk_i,
	input wire rst_n_i,
	input wire spi_sel_n_i,
	input wire spi_miso_o,
	input wire spi_miso_oe_o,
	input wire tx_start_i,
	input wire tx_byte_req_i,
	input wire [7:0] tx_byte_o,
	input wire buffer_access_conflict_irq_o
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_oe_on_select: assert property (!spi_sel_n_i [*3] |-> spi_miso_oe_o)
		else $error("miso enable missing while selected");
	a_oe_off_idle: assert property (spi_sel_n_i [*3] |-> !spi_miso_oe_o)
		else $error("miso enable while deselected");
	a_oe_rise_lag: assert property ($rose(spi_miso_oe_o) |-> $past(!spi_sel_n_i, 2))
		else $error("miso enable rose without select");
	a_miso_idle_low: assert property (spi_sel_n_i [*5] |-> !spi_miso_o)
		else $error("miso high while deselected");
	a_irq_one_cycle: assert property (buffer_access_conflict_irq_o |=> !buffer_access_conflict_irq_o)
		else $error("conflict pulse too long");
	a_irq_host_only: assert property (spi_sel_n_i [*8] |-> !buffer_access_conflict_irq_o)
		else $error("conflict without host session");
	a_tx_on_request: assert property ($changed(tx_byte_o) |-> $past(tx_byte_req_i) || $past(tx_start_i))
		else $error("transmit byte changed unasked");
	a_reset_clear: assert property ($rose(rst_n_i) |-> !buffer_access_conflict_irq_o && tx_byte_o == 8'h00)
		else $error("outputs not clear after reset");
endmodule // frame_buffer_monitor

// ### verif/spi_host_model.sv
// Host controller model: byte transfers on the serial link, mode 0.
// Assumes an 800 ns serial period built from the 100 ns core clock.
`timescale 1ns/1ps
module spi_host_model (
	input wire clk_i,
	output reg spi_sclk_o,
	output reg spi_sel_n_o,
	output reg spi_mosi_o,
	input wire spi_miso_i
);
	// Idle: clock low, deselected
	initial begin
		spi_sclk_o = 1'b0;
		spi_sel_n_o = 1'b1;
		spi_mosi_o = 1'b1;
	end
	// Select or release; data line parked inverted
	task sel(input reg on);
		begin
			@(negedge clk_i);
			spi_sel_n_o = !on;
			spi_mosi_o = !spi_mosi_o;
			repeat (4) @(negedge clk_i);
		end
	endtask
	// One byte, MSB first, sampled at the rising serial clock
	task xfer(input reg [7:0] tx, output reg [7:0] rx);
		integer b;
		begin
			for (b = 7; b >= 0; b = b - 1) begin
				spi_mosi_o = tx[b];
				repeat (4) @(negedge clk_i);
				spi_sclk_o = 1'b1;
				rx[b] = spi_miso_i;
				repeat (4) @(negedge clk_i);
				spi_sclk_o = 1'b0;
			end
		end
	endtask
endmodule // spi_host_model

// ### verif/radio_frame_buffer_energy_detect_tb.sv
// Self-checking bench: host model on the serial link, engine pins driven here.
// Assumes frame_buffer with a 10 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ps
module radio_frame_buffer_energy_detect_tb;
	reg clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg rx_state_i, auto_retry_tx_state_i, sleep_i, power_on_i, frame_start_i;
	reg rx_byte_valid_i, frame_end_i, tx_start_i, tx_byte_req_i, irq_seen = 0;
	reg [7:0] rx_byte_i;
	reg [7:0] link_quality_i;
	reg [4:0] rssi_raw_i;
	wire sclk, sel_n, mosi, miso, irq;
	wire [7:0] tx_byte_o;
	integer failures = 0, check_count = 0, cycles = 0, i, k;
	reg [7:0] d, got [0:7], xp [0:7];
	reg [20:0] rows [0:3];
	reg [15:0] crc;
	frame_buffer u_frame_buffer (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_sel_n_i(sel_n),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(), .rx_state_i(rx_state_i),
		.auto_retry_tx_state_i(auto_retry_tx_state_i), .sleep_i(sleep_i), .power_on_i(power_on_i),
		.frame_start_i(frame_start_i), .rx_byte_valid_i(rx_byte_valid_i), .rx_byte_i(rx_byte_i),
		.frame_end_i(frame_end_i), .link_quality_i(link_quality_i), .rssi_raw_i(rssi_raw_i),
		.tx_start_i(tx_start_i), .tx_byte_req_i(tx_byte_req_i), .tx_byte_o(tx_byte_o),
		.buffer_access_conflict_irq_o(irq));
	spi_host_model u_host (.clk_i(clk_i), .spi_sclk_o(sclk), .spi_sel_n_o(sel_n), .spi_mosi_o(mosi),
		.spi_miso_i(miso));
	// ----
	// Clock, hang guard, conflict latch
	// ----
	always #50 clk_i = !clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (irq === 1'b1) irq_seen <= 1'b1;
		if (cycles == 30000) begin
			failures = failures + 1;
			stop_test;
		end
	end
	// Compare and verdict
	task chk(input [7:0] g, input [7:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("BAD %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	task stop_test;
		begin
			$display("failures %0d checks %0d", failures, check_count);
			if (failures == 0 && check_count > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// Register and buffer access over the host model
	task wr_reg(input [5:0] a, input [7:0] v);
		begin
			u_host.sel(1);
			u_host.xfer({2'b11, a}, d);
			u_host.xfer(v, d);
			u_host.sel(0);
		end
	endtask
	task rd_reg(input [5:0] a);
		begin
			u_host.sel(1);
			u_host.xfer({2'b10, a}, d);
			u_host.xfer(8'h00, d);
			u_host.sel(0);
		end
	endtask
	task rd_frame(input integer n, input [7:0] cmd);
		begin
			u_host.sel(1);
			u_host.xfer(cmd, d);
			for (i = 0; i < n; i = i + 1) u_host.xfer(8'h00, got[i]);
			u_host.sel(0);
		end
	endtask
	task wr_frame(input integer n);
		begin
			u_host.sel(1);
			u_host.xfer(8'h60, d);
			for (i = 0; i < n; i = i + 1) u_host.xfer(xp[i], d);
			u_host.sel(0);
		end
	endtask
	task cmp(input integer n);
		for (i = 0; i < n; i = i + 1) chk(got[i], xp[i]);
	endtask
	// Engine side: delimiter, octets after takeover, end with quality byte
	task rx_frame(input [7:0] len);
		begin
			frame_start_i = 1;
			@(negedge clk_i) frame_start_i = 0;
			repeat (330) @(negedge clk_i);
			for (i = 0; i <= len[6:0]; i = i + 1) begin
				rx_byte_i = (i == 0) ? len : 8'hA0 + i[7:0];
				rx_byte_valid_i = 1;
				@(negedge clk_i) rx_byte_valid_i = 0;
				@(negedge clk_i);
			end
			link_quality_i = len ^ 8'h5A;
			frame_end_i = 1;
			@(negedge clk_i) frame_end_i = 0;
		end
	endtask
	task tx_run(input integer n);
		begin
			tx_start_i = 1;
			@(negedge clk_i) tx_start_i = 0;
			for (i = 0; i < n; i = i + 1) begin
				tx_byte_req_i = 1;
				@(negedge clk_i) tx_byte_req_i = 0;
				@(negedge clk_i) chk(tx_byte_o, xp[i]);
			end
		end
	endtask
	// Main sequence
	initial begin
		{rx_state_i, auto_retry_tx_state_i, sleep_i, power_on_i, frame_start_i} = 5'h00;
		{rx_byte_valid_i, frame_end_i, tx_start_i, tx_byte_req_i} = 4'h0;
		rx_byte_i = 8'h00;
		link_quality_i = 8'h00;
		rssi_raw_i = 5'h00;
		rows[0] = {5'h00, 8'h00, 8'h00};
		rows[1] = {5'h0A, 8'h0A, 8'h1E};
		rows[2] = {5'h1C, 8'h1C, 8'h54};
		rows[3] = {5'h1F, 8'h1C, 8'h54};
		repeat (6) @(negedge clk_i);
		rst_n_i = 1;
		repeat (4) @(negedge clk_i);
		rd_reg(6'h07);
		chk(d, 8'h00);
		rx_state_i = 1;
		for (k = 0; k < 4; k = k + 1) begin
			rssi_raw_i = rows[k][20:16];
			wr_reg(6'h07, 8'hA5);
			repeat (1450) @(negedge clk_i);
			rd_reg(6'h06);
			chk(d, rows[k][15:8]);
			rd_reg(6'h07);
			chk(d, rows[k][7:0]);
		end
		irq_seen = 0;
		rx_frame(8'h83);
		rd_reg(6'h07);
		chk(d, 8'h00);
		chk({7'h00, irq_seen}, 8'h00);
		xp[0] = 8'h03; xp[1] = 8'hA1; xp[2] = 8'hA2; xp[3] = 8'hA3; xp[4] = 8'hD9;
		rd_frame(5, 8'h20);
		cmp(5);
		chk(got[4], 8'h83 ^ 8'h5A);
		rd_frame(3, 8'h00);
		chk(got[1], 8'h00);
		auto_retry_tx_state_i = 1;
		rx_frame(8'h82);
		auto_retry_tx_state_i = 0;
		rx_state_i = 0;
		rd_frame(5, 8'h20);
		cmp(5);
		chk(got[0], 8'h03);
		rx_state_i = 1;
		irq_seen = 0;
		u_host.sel(1);
		u_host.xfer(8'h20, d);
		rx_frame(8'h81);
		u_host.sel(0);
		chk({7'h00, irq_seen}, 8'h01);
		rx_state_i = 0;
		rd_reg(6'h06);
		chk(d, 8'h00);
		xp[0] = 8'h05; xp[1] = 8'h11; xp[2] = 8'h22; xp[3] = 8'h33;
		wr_frame(4);
		wr_reg(6'h05, 8'h80);
		rd_reg(6'h05);
		chk(d, 8'h80);
		crc = 16'h0000;
		for (k = 1; k < 4; k = k + 1)
			for (i = 0; i < 8; i = i + 1) crc = (crc[0] ^ xp[k][i]) ? (crc >> 1) ^ 16'h8408 : crc >> 1;
		xp[4] = crc[7:0];
		xp[5] = crc[15:8];
		tx_run(6);
		xp[0] = 8'h01; xp[1] = 8'h77;
		// Host write while the engine is sending collides
		tx_start_i = 1;
		@(negedge clk_i) tx_start_i = 0;
		irq_seen = 0;
		wr_frame(2);
		chk({7'h00, irq_seen}, 8'h01);
		tx_run(2);
		// Power-on state refuses host writes and reads
		power_on_i = 1;
		xp[0] = 8'h7F;
		wr_frame(1);
		rd_frame(1, 8'h20);
		chk(got[0], 8'h00);
		power_on_i = 0;
		rd_frame(2, 8'h20);
		chk(got[0], 8'h01);
		chk(got[1], 8'h77);
		// Reset in mid-run returns the configuration to its default
		rst_n_i = 0;
		repeat (2) @(negedge clk_i);
		rst_n_i = 1;
		repeat (4) @(negedge clk_i);
		rd_reg(6'h05);
		chk(d, 8'h00);
		sleep_i = 1;
		rd_frame(1, 8'h20);
		chk(got[0], 8'h00);
		sleep_i = 0;
		stop_test;
	end
endmodule // radio_frame_buffer_energy_detect_tb
bind frame_buffer frame_buffer_monitor u_frame_buffer_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.spi_sel_n_i(spi_sel_n_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .tx_start_i(tx_start_i),
	.tx_byte_req_i(tx_byte_req_i), .tx_byte_o(tx_byte_o), .buffer_access_conflict_irq_o(buffer_access_conflict_irq_o));
